// File: design/port_group_pkg.sv
// package of register map, field positions and carriers for the port group
package port_group_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] PORT_B_DATA_OFS              = 8'h06;
  localparam logic [7:0] PORT_C_DATA_OFS              = 8'h07;
  localparam logic [7:0] PORT_D_DATA_OFS              = 8'h08;
  localparam logic [7:0] INTERRUPT_CONTROL_OFS        = 8'h0b;
  localparam logic [7:0] OPTION_CONTROL_OFS           = 8'h81;
  localparam logic [7:0] PORT_B_DIRECTION_OFS         = 8'h86;
  localparam logic [7:0] PORT_C_DIRECTION_OFS         = 8'h87;
  localparam logic [7:0] PORT_D_DIRECTION_OFS         = 8'h88;
  localparam logic [7:0] PORT_E_DIRECTION_CONTROL_OFS = 8'h89;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] OPTION_CONTROL_RST  = 8'hff;
  localparam logic [7:0] DIRECTION_RST       = 8'hff;
  localparam logic [7:0] PORT_E_CONTROL_RST  = 8'h07;
  localparam logic [7:0] DATA_LATCH_RST      = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PULLUP_DISABLE_N_BIT      = 7;  // option_control
  localparam int EXT_IRQ_EDGE_BIT          = 6;  // option_control, 1 = rising
  localparam int PORT_CHANGE_FLAG_BIT      = 0;  // interrupt_control
  localparam int EXT_IRQ_FLAG_BIT          = 1;  // interrupt_control
  localparam int PARALLEL_SLAVE_SELECT_BIT = 4;  // port_e_direction_control
  localparam logic [7:0] PORT_E_CONTROL_MASK = 8'h17;  // writable bits
  localparam int EXT_IRQ_PIN               = 0;  // port b
  localparam int CHANGE_LO                 = 4;  // port b change pins 7..4
  localparam int PROG_CLK_PIN              = 6;  // port b
  localparam int PROG_DAT_PIN              = 7;  // port b

  // port c alternate pin positions
  localparam int TIMER_OSC_CLK_PIN  = 0;
  localparam int TIMER_OSC_CMP2_PIN = 1;
  localparam int CMP1_PIN           = 2;
  localparam int SERIAL_CLK_PIN     = 3;
  localparam int SERIAL_DIN_PIN     = 4;
  localparam int SERIAL_DOUT_PIN    = 5;
  localparam int UART_TX_PIN        = 6;
  localparam int UART_RX_PIN        = 7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // one 8-bit pin group as driven by the block
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;

  // peripheral requests on the eight port c pins
  typedef struct packed {
    logic [7:0] sel;  // 1 = peripheral owns the pin
    logic [7:0] out;  // peripheral output value
    logic [7:0] oe;   // peripheral output enable
  } periph_s;

  // serial programming use of port b pins 6 and 7
  typedef struct packed {
    logic mode;     // programming mode active
    logic dat_out;  // data driven back on pin 7
    logic dat_oe;   // drive enable for pin 7
  } prog_s;

endpackage : port_group_pkg

// File: design/multiplexed_port_group.sv
// port b, c and d pin logic with register port, pull-ups and change detection
`timescale 1ns/100ps

// Summary of operation
// - port c has eight two-way pins, each with its own direction bit
// - software sets each port c pin input or output via its direction register
// - an enabled peripheral overrides the port c direction bit, output or input
// - per-pin select picks latch value or peripheral value for the driver
// - peripheral drive enable counts only while its pin select is active
// - port d has eight pins, each independently input or output
// - control bit 4 of the port e register makes port d a parallel slave port
// - port b pin 0 is general i/o and the external interrupt input
// - only port b pins 4 to 7 take part in change detection
// - every port b pin has a software switched weak pull-up
// - in programming mode port b pin 6 is clock and pin 7 is data
// - port c pin 3 is serial clock, pin 4 serial data in or line
// - port c pin 5 can carry the serial data output
// - port c pin 2 can carry capture in, compare out or pwm out
// - port c pins 0 and 1 carry the timer oscillator and clock input
// - port c pins 6 and 7 carry uart transmit/clock and receive/data
// - direction one floats the driver, zero drives the latch onto the pin
// - data read returns pins; data write loads the latch
// - option bit 7 low enables pull-ups; outputs and reset turn them off
// - input pins 4 to 7 compared with value sampled at last port b read or write set the change flag
module multiplexed_port_group (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire port_group_pkg::reg_req_s   reg_req_in,
  output logic [7:0]                      reg_rdata_out,
  input  wire logic [7:0]                 port_b_pin_in,
  output port_group_pkg::pin_drive_s      port_b_drive_out,
  output logic [7:0]                      port_b_pullup_en_out,
  input  wire logic [7:0]                 port_c_pin_in,
  output port_group_pkg::pin_drive_s      port_c_drive_out,
  input  wire port_group_pkg::periph_s    port_c_periph_in,
  output logic [7:0]                      port_c_level_out,
  input  wire logic [7:0]                 port_d_pin_in,
  output port_group_pkg::pin_drive_s      port_d_drive_out,
  output logic                            parallel_slave_select_out,
  output logic [2:0]                      port_e_direction_out,
  input  wire port_group_pkg::prog_s      prog_in,
  output logic                            prog_clk_level_out,
  output logic                            prog_dat_level_out,
  output logic                            ext_irq_level_out,
  output logic                            port_change_flag_out,
  output logic                            ext_irq_flag_out
);
  import port_group_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] b_meta;
  logic [7:0] b_sync;
  logic [7:0] c_meta;
  logic [7:0] c_sync;
  logic [7:0] d_meta;
  logic [7:0] d_sync;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge ref_clk_in) begin
    b_meta <= port_b_pin_in;
    b_sync <= b_meta;
    c_meta <= port_c_pin_in;
    c_sync <= c_meta;
    d_meta <= port_d_pin_in;
    d_sync <= d_meta;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] port_b_data;
  logic [7:0] port_c_data;
  logic [7:0] port_d_data;
  logic [7:0] option_control;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_direction;
  logic [7:0] port_e_direction_control;
  logic [3:0] change_snapshot;
  logic       port_change_flag;
  logic       ext_irq_flag;
  logic       ext_irq_prev;
  logic [1:0] warm_up;

  // address decode
  wire logic wr_b_data   = reg_req_in.wr && reg_req_in.addr == PORT_B_DATA_OFS;
  wire logic wr_c_data   = reg_req_in.wr && reg_req_in.addr == PORT_C_DATA_OFS;
  wire logic wr_d_data   = reg_req_in.wr && reg_req_in.addr == PORT_D_DATA_OFS;
  wire logic wr_intctl   = reg_req_in.wr && reg_req_in.addr == INTERRUPT_CONTROL_OFS;
  wire logic wr_option   = reg_req_in.wr && reg_req_in.addr == OPTION_CONTROL_OFS;
  wire logic wr_b_dir    = reg_req_in.wr && reg_req_in.addr == PORT_B_DIRECTION_OFS;
  wire logic wr_c_dir    = reg_req_in.wr && reg_req_in.addr == PORT_C_DIRECTION_OFS;
  wire logic wr_d_dir    = reg_req_in.wr && reg_req_in.addr == PORT_D_DIRECTION_OFS;
  wire logic wr_e_ctl    = reg_req_in.wr && reg_req_in.addr == PORT_E_DIRECTION_CONTROL_OFS;
  wire logic rd_b_data   = reg_req_in.rd && reg_req_in.addr == PORT_B_DATA_OFS;
  wire logic b_access    = rd_b_data || wr_b_data;

  // data latches: a byte write carries the whole modified value
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      port_b_data <= DATA_LATCH_RST;
      port_c_data <= DATA_LATCH_RST;
      port_d_data <= DATA_LATCH_RST;
    end else begin
      if (wr_b_data) port_b_data <= reg_req_in.wdata;
      if (wr_c_data) port_c_data <= reg_req_in.wdata;
      if (wr_d_data) port_d_data <= reg_req_in.wdata;
    end
  end

  // option and direction registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      option_control           <= OPTION_CONTROL_RST;  // pull-ups off at reset
      port_b_direction         <= DIRECTION_RST;
      port_c_direction         <= DIRECTION_RST;
      port_d_direction         <= DIRECTION_RST;
      port_e_direction_control <= PORT_E_CONTROL_RST;
    end else begin
      if (wr_option) option_control <= reg_req_in.wdata;
      if (wr_b_dir)  port_b_direction <= reg_req_in.wdata;
      if (wr_c_dir)  port_c_direction <= reg_req_in.wdata;
      if (wr_d_dir)  port_d_direction <= reg_req_in.wdata;
      if (wr_e_ctl)  port_e_direction_control <= reg_req_in.wdata & PORT_E_CONTROL_MASK;
    end
  end

  // ****************************************************************
  // change detection and external interrupt
  // ****************************************************************
  wire logic [3:0] change_inputs = port_b_direction[7:CHANGE_LO];
  wire logic [3:0] mismatch      = (b_sync[7:CHANGE_LO] ^ change_snapshot) & change_inputs;
  wire logic       armed         = warm_up[1];  // synchronisers hold real levels
  wire logic       change_event  = armed && |mismatch;
  wire logic       ext_level     = b_sync[EXT_IRQ_PIN];
  wire logic       ext_rise      = ext_level && !ext_irq_prev;
  wire logic       ext_fall      = !ext_level && ext_irq_prev;
  wire logic       ext_edge      = option_control[EXT_IRQ_EDGE_BIT] ? ext_rise : ext_fall;
  wire logic       ext_event     = armed && ext_edge;
  wire logic       clr_change    = wr_intctl && !reg_req_in.wdata[PORT_CHANGE_FLAG_BIT];
  wire logic       clr_ext       = wr_intctl && !reg_req_in.wdata[EXT_IRQ_FLAG_BIT];

  // snapshot taken on any port b access ends the mismatch; after reset the
  // snapshot and edge memory track the pins first, so no false event follows
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      change_snapshot <= 4'h0;
      ext_irq_prev    <= 1'b0;
      warm_up         <= 2'h0;
    end else begin
      warm_up <= {warm_up[0], 1'b1};
      if (!armed || b_access) change_snapshot <= b_sync[7:CHANGE_LO];
      ext_irq_prev <= ext_level;
    end
  end

  // sticky flags: an event in the clearing cycle wins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      port_change_flag <= 1'b0;
      ext_irq_flag     <= 1'b0;
    end else begin
      port_change_flag <= change_event || (port_change_flag && !clr_change);
      ext_irq_flag     <= ext_event || (ext_irq_flag && !clr_ext);
    end
  end

  // ****************************************************************
  // pin drive selection
  // ****************************************************************
  wire logic       pullup_on   = !option_control[PULLUP_DISABLE_N_BIT];
  wire logic       psp_mode    = port_e_direction_control[PARALLEL_SLAVE_SELECT_BIT];
  logic [7:0]      next_c_out;
  logic [7:0]      next_c_oe;
  logic [7:0]      next_b_out;
  logic [7:0]      next_b_oe;

  // per-pin mux for port c: peripheral or latch/direction
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // select chooses value and drive enable source
      assign next_c_out[gi] = port_c_periph_in.sel[gi] ? port_c_periph_in.out[gi]
                                                      : port_c_data[gi];
      assign next_c_oe[gi]  = port_c_periph_in.sel[gi] ? port_c_periph_in.oe[gi]
                                                      : !port_c_direction[gi];
    end
  endgenerate

  // port b: programming mode takes pins 6 and 7
  always_comb begin
    next_b_out = port_b_data;
    next_b_oe  = ~port_b_direction;
    if (prog_in.mode) begin
      next_b_oe[PROG_CLK_PIN]  = 1'b0;
      next_b_out[PROG_DAT_PIN] = prog_in.dat_out;
      next_b_oe[PROG_DAT_PIN]  = prog_in.dat_oe;
    end
  end

  // registered pin drivers and status outputs
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      port_b_drive_out          <= '0;
      port_c_drive_out          <= '0;
      port_d_drive_out          <= '0;
      port_b_pullup_en_out      <= 8'h00;
      port_c_level_out          <= 8'h00;
      parallel_slave_select_out <= 1'b0;
      port_e_direction_out      <= PORT_E_CONTROL_RST[2:0];
    end else begin
      port_b_drive_out.out      <= next_b_out;
      port_b_drive_out.oe       <= next_b_oe;
      port_c_drive_out.out      <= next_c_out;
      port_c_drive_out.oe       <= next_c_oe;
      port_d_drive_out.out      <= port_d_data;
      port_d_drive_out.oe       <= psp_mode ? 8'h00 : ~port_d_direction;
      port_b_pullup_en_out      <= pullup_on ? ~next_b_oe : 8'h00;
      port_c_level_out          <= c_sync;
      parallel_slave_select_out <= psp_mode;
      port_e_direction_out      <= port_e_direction_control[2:0];
    end
  end

  // programming and interrupt pin levels for the core
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prog_clk_level_out   <= 1'b0;
      prog_dat_level_out   <= 1'b0;
      ext_irq_level_out    <= 1'b0;
      port_change_flag_out <= 1'b0;
      ext_irq_flag_out     <= 1'b0;
    end else begin
      prog_clk_level_out   <= prog_in.mode && b_sync[PROG_CLK_PIN];
      prog_dat_level_out   <= prog_in.mode && b_sync[PROG_DAT_PIN];
      ext_irq_level_out    <= ext_level;
      port_change_flag_out <= port_change_flag;
      ext_irq_flag_out     <= ext_irq_flag;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] rd_mux;

  // data registers return pin levels, others their contents
  always_comb begin
    rd_mux = 8'h00;
    case (reg_req_in.addr)
      PORT_B_DATA_OFS:              rd_mux = b_sync;
      PORT_C_DATA_OFS:              rd_mux = c_sync;
      PORT_D_DATA_OFS:              rd_mux = d_sync;
      INTERRUPT_CONTROL_OFS:        rd_mux = {6'h00, ext_irq_flag, port_change_flag};
      OPTION_CONTROL_OFS:           rd_mux = option_control;
      PORT_B_DIRECTION_OFS:         rd_mux = port_b_direction;
      PORT_C_DIRECTION_OFS:         rd_mux = port_c_direction;
      PORT_D_DIRECTION_OFS:         rd_mux = port_d_direction;
      PORT_E_DIRECTION_CONTROL_OFS: rd_mux = port_e_direction_control;
      default:                      rd_mux = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_req_in.rd ? rd_mux : 8'h00;
    end
  end

endmodule // multiplexed_port_group

// File: dv/pin_world.sv
// external circuitry model resolving the level on one group of eight pins
`timescale 1ns/100ps
module pin_world (
  input  wire logic                       ref_clk_in,
  input  wire port_group_pkg::pin_drive_s drive_in,
  input  wire logic [7:0]                 pullup_in,
  input  wire logic [7:0]                 ext_val_in,
  input  wire logic [7:0]                 ext_oe_in,
  output logic [7:0]                      pin_out
);
  import port_group_pkg::*;
  logic [7:0] last;
  // ****************************************************************
  // pin resolution
  // ****************************************************************
  // block wins, then outside driver; a released pin pulls up or shows the inverse of its last level
  assign pin_out = (drive_in.oe & drive_in.out) | (~drive_in.oe & ext_oe_in & ext_val_in)
                 | (~drive_in.oe & ~ext_oe_in & (pullup_in | ~last));
  // memory of the last level, so an undriven line never looks stable
  always_ff @(posedge ref_clk_in) begin
    last <= pin_out;
  end
endmodule // pin_world

// File: dv/port_group_sva.sv
// concurrent checks on the port group register port and pin drivers
`timescale 1ns/100ps
module port_group_sva (
  input wire logic                       ref_clk_in,
  input wire logic                       rst_in,
  input wire port_group_pkg::reg_req_s   reg_req_in,
  input wire logic [7:0]                 reg_rdata_out,
  input wire port_group_pkg::pin_drive_s port_b_drive_out,
  input wire logic [7:0]                 port_b_pullup_en_out,
  input wire port_group_pkg::pin_drive_s port_c_drive_out,
  input wire port_group_pkg::periph_s    port_c_periph_in,
  input wire port_group_pkg::pin_drive_s port_d_drive_out,
  input wire logic                       parallel_slave_select_out,
  input wire logic [2:0]                 port_e_direction_out,
  input wire port_group_pkg::prog_s      prog_in,
  input wire logic                       port_change_flag_out
);
  import port_group_pkg::*;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  logic ic_wr;
  logic cdir_wr;
  // decoded writes of the flag register and the port c direction register
  assign ic_wr   = reg_req_in.wr && (reg_req_in.addr == INTERRUPT_CONTROL_OFS);
  assign cdir_wr = reg_req_in.wr && (reg_req_in.addr == PORT_C_DIRECTION_OFS);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_rdata_idle;
    !reg_req_in.rd |=> reg_rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data seen outside the answer cycle");
  property p_reset_vals;
    $fell(rst_in) |-> port_b_pullup_en_out == 8'h00 && port_b_drive_out.oe == 8'h00
      && port_c_drive_out.oe == 8'h00 && port_e_direction_out == 3'h7 && !port_change_flag_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong output values after reset");
  property p_periph_oe;
    !rst_in |=> (port_c_drive_out.oe & $past(port_c_periph_in.sel))
      == $past(port_c_periph_in.sel & port_c_periph_in.oe);
  endproperty
  a_periph_oe: assert property (p_periph_oe)
    else $error("selected pin enable differs from peripheral enable");
  property p_periph_out;
    !rst_in |=> (port_c_drive_out.out & $past(port_c_periph_in.sel))
      == $past(port_c_periph_in.sel & port_c_periph_in.out);
  endproperty
  a_periph_out: assert property (p_periph_out)
    else $error("selected pin value differs from peripheral value");
  property p_psp_float;
    parallel_slave_select_out && $past(parallel_slave_select_out) |-> port_d_drive_out.oe == 8'h00;
  endproperty
  a_psp_float: assert property (p_psp_float)
    else $error("port d driven in parallel slave mode");
  property p_prog_pins;
    !$past(rst_in) && $past(prog_in.mode) |-> !port_b_drive_out.oe[PROG_CLK_PIN]
      && port_b_drive_out.oe[PROG_DAT_PIN] == $past(prog_in.dat_oe);
  endproperty
  a_prog_pins: assert property (p_prog_pins)
    else $error("programming pins not handed over");
  property p_dir_drive;
    cdir_wr && port_c_periph_in.sel == 8'h00 ##1 !cdir_wr && port_c_periph_in.sel == 8'h00
      |=> port_c_drive_out.oe == ~$past(reg_req_in.wdata, 2);
  endproperty
  a_dir_drive: assert property (p_dir_drive)
    else $error("port c enable does not follow direction write");
  property p_change_sticky;
    port_change_flag_out && !ic_wr && !$past(ic_wr) |=> port_change_flag_out;
  endproperty
  a_change_sticky: assert property (p_change_sticky)
    else $error("change flag dropped without a clear");
endmodule // port_group_sva

bind multiplexed_port_group port_group_sva u_port_group_sva (
  .ref_clk_in, .rst_in, .reg_req_in, .reg_rdata_out, .port_b_drive_out, .port_b_pullup_en_out,
  .port_c_drive_out, .port_c_periph_in, .port_d_drive_out, .parallel_slave_select_out,
  .port_e_direction_out, .prog_in, .port_change_flag_out
);

// File: dv/tb.sv
// self-checking bench for the port group with external pin models
`timescale 1ns/100ps
module tb;
  import port_group_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  reg_req_s   reg_req_in = '0;
  periph_s    port_c_periph_in = '0;
  prog_s      prog_in    = '0;
  pin_drive_s port_b_drive_out, port_c_drive_out, port_d_drive_out;
  logic [7:0] reg_rdata_out, port_b_pin_in, port_b_pullup_en_out, port_c_pin_in, port_d_pin_in;
  logic [7:0] port_c_level_out, b_ev = 8'h00, c_ev = 8'h00, d_ev = 8'h00;
  logic [7:0] b_eo = 8'hff, c_eo = 8'hff, d_eo = 8'hff;
  logic [2:0] port_e_direction_out;
  logic       parallel_slave_select_out, prog_clk_level_out, prog_dat_level_out;
  logic       ext_irq_level_out, port_change_flag_out, ext_irq_flag_out;
  int         mismatches = 0;
  int         check_count = 0;
  // ****************************************************************
  // design and pin models
  // ****************************************************************
  multiplexed_port_group u_multiplexed_port_group (.ref_clk_in, .rst_in, .reg_req_in,
    .reg_rdata_out, .port_b_pin_in, .port_b_drive_out, .port_b_pullup_en_out, .port_c_pin_in,
    .port_c_drive_out, .port_c_periph_in, .port_c_level_out, .port_d_pin_in, .port_d_drive_out,
    .parallel_slave_select_out, .port_e_direction_out, .prog_in, .prog_clk_level_out,
    .prog_dat_level_out, .ext_irq_level_out, .port_change_flag_out, .ext_irq_flag_out);
  pin_world u_pin_b (.ref_clk_in, .drive_in(port_b_drive_out), .pullup_in(port_b_pullup_en_out),
    .ext_val_in(b_ev), .ext_oe_in(b_eo), .pin_out(port_b_pin_in));
  pin_world u_pin_c (.ref_clk_in, .drive_in(port_c_drive_out), .pullup_in(8'h00),
    .ext_val_in(c_ev), .ext_oe_in(c_eo), .pin_out(port_c_pin_in));
  pin_world u_pin_d (.ref_clk_in, .drive_in(port_d_drive_out), .pullup_in(8'h00),
    .ext_val_in(d_ev), .ext_oe_in(d_eo), .pin_out(port_d_pin_in));
  // clock
  always #5 ref_clk_in = ~ref_clk_in;
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_req_in <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_in);
    reg_req_in.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_req_in <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_in);
    reg_req_in.rd <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic settle();
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values, unmapped address and a direction write read back
  task automatic t_regs();
    rdchk(OPTION_CONTROL_OFS, 8'hff);
    rdchk(PORT_B_DIRECTION_OFS, 8'hff);
    rdchk(PORT_C_DIRECTION_OFS, 8'hff);
    rdchk(PORT_D_DIRECTION_OFS, 8'hff);
    rdchk(PORT_E_DIRECTION_CONTROL_OFS, 8'h07);
    wr(8'h55, 8'hff);
    rdchk(8'h55, 8'h00);
    wr(PORT_C_DIRECTION_OFS, 8'h5a);
    rdchk(PORT_C_DIRECTION_OFS, 8'h5a);
  endtask
  // port c as plain i/o, mixed directions, pins read back
  task automatic t_gpio_c();
    wr(PORT_C_DATA_OFS, 8'ha5);
    wr(PORT_C_DIRECTION_OFS, 8'h0f);
    c_ev <= 8'h3c;
    c_eo <= 8'h0f;
    settle();
    chk(port_c_drive_out.oe, 8'hf0);
    chk(port_c_drive_out.out, 8'ha5);
    chk(port_c_level_out, 8'hac);
    rdchk(PORT_C_DATA_OFS, 8'hac);
  endtask
  // peripherals taking port c pins, several at once then one at a time
  task automatic t_periph();
    logic [7:0] m;
    @(posedge ref_clk_in);
    port_c_periph_in <= '{8'h2c, 8'h08, 8'h0c};
    wr(PORT_C_DIRECTION_OFS, 8'h0f);
    settle();
    chk(port_c_drive_out.oe, 8'hdc);
    chk(port_c_drive_out.out, 8'h89);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      @(posedge ref_clk_in);
      port_c_periph_in <= '{m, 8'h5a, 8'h0f};
      settle();
      chk(port_c_drive_out.oe, (8'hf0 & ~m) | (8'h0f & m));
      chk(port_c_drive_out.out, (8'ha5 & ~m) | (8'h5a & m));
    end
    @(posedge ref_clk_in);
    port_c_periph_in <= '0;
  endtask
  // pull-ups on inputs only, switched by the option bit
  task automatic t_pullup();
    wr(PORT_B_DIRECTION_OFS, 8'hf0);
    wr(OPTION_CONTROL_OFS, 8'h7f);
    settle();
    chk(port_b_pullup_en_out, 8'hf0);
    chk(port_b_drive_out.oe, 8'h0f);
    wr(OPTION_CONTROL_OFS, 8'hff);
    settle();
    chk(port_b_pullup_en_out, 8'h00);
  endtask
  // change detection on the upper pins and the edge input on pin 0
  task automatic t_change();
    wr(PORT_B_DIRECTION_OFS, 8'hff);
    rdchk(PORT_B_DATA_OFS, 8'h00);
    wr(INTERRUPT_CONTROL_OFS, 8'h00);
    b_ev <= 8'h0e;
    settle();
    chk({7'h00, port_change_flag_out}, 8'h00);
    @(posedge ref_clk_in);
    b_ev <= 8'h2f;
    settle();
    chk({6'h00, port_change_flag_out, ext_irq_flag_out}, 8'h03);
    chk({7'h00, ext_irq_level_out}, 8'h01);
    rdchk(INTERRUPT_CONTROL_OFS, 8'h03);
    wr(INTERRUPT_CONTROL_OFS, 8'h00);
    settle();
    chk({7'h00, port_change_flag_out}, 8'h01);
    rdchk(PORT_B_DATA_OFS, 8'h2f);
    wr(INTERRUPT_CONTROL_OFS, 8'h00);
    settle();
    chk({6'h00, port_change_flag_out, ext_irq_flag_out}, 8'h00);
    wr(OPTION_CONTROL_OFS, 8'hbf);
    b_ev <= 8'h0e;
    settle();
    chk({6'h00, port_change_flag_out, ext_irq_flag_out}, 8'h03);
  endtask
  // programming mode owns pins 6 and 7
  task automatic t_prog();
    @(posedge ref_clk_in);
    prog_in <= '{1'b1, 1'b1, 1'b1};
    b_ev <= 8'h40;
    wr(PORT_B_DIRECTION_OFS, 8'h00);
    settle();
    chk(port_b_drive_out.oe & 8'hc0, 8'h80);
    chk(port_b_drive_out.out & 8'hc0, 8'h80);
    chk({6'h00, prog_clk_level_out, prog_dat_level_out}, 8'h03);
    @(posedge ref_clk_in);
    prog_in <= '0;
  endtask
  // port d as outputs, then handed to the parallel slave port
  task automatic t_port_d();
    wr(PORT_D_DATA_OFS, 8'h3c);
    wr(PORT_D_DIRECTION_OFS, 8'h00);
    settle();
    chk(port_d_drive_out.oe, 8'hff);
    chk(port_d_drive_out.out, 8'h3c);
    rdchk(PORT_D_DATA_OFS, 8'h3c);
    wr(PORT_E_DIRECTION_CONTROL_OFS, 8'hf0);
    settle();
    chk(port_d_drive_out.oe, 8'h00);
    chk({4'h0, parallel_slave_select_out, port_e_direction_out}, 8'h08);
    rdchk(PORT_E_DIRECTION_CONTROL_OFS, 8'h10);
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_gpio_c();
    t_periph();
    t_pullup();
    t_change();
    t_prog();
    t_port_d();
    print_verdict();
  end
  // cut a hang short well beyond the expected few hundred cycles
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule // tb
